// ---- rtl/dar_regs.vh ----
// Offsets, field positions and reset values of the descriptor attribute registers
`ifndef DAR_REGS_VH
`define DAR_REGS_VH
// Register byte offsets
`define DAR_TX_PTR_DEBUG_OFF   8'h7C
`define DAR_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES_OFF        8'hA0
`define DAR_FULL_SPEED_DESCRIPTOR_ATTRIBUTES_OFF        8'hA4
`define DAR_STR_LEN_A_OFF      8'hA8
`define DAR_STR_LEN_B_OFF      8'hAC
`define DAR_EMULATED_FLAG_ATTRIBUTES_OFF      8'hB0
// Pointer field positions
`define DAR_RD_POS_LSB         16
`define DAR_WR_POS_LSB         0
// Interval and size field positions
`define DAR_INTERVAL_LSB       16
`define DAR_DEVICE_LEN_LSB     8
`define DAR_CONFIG_LEN_LSB     0
// Flag field positions
`define DAR_HOST_WAKEUP_BIT    17
`define DAR_SUPPLY_SEL_BIT     16
`define DAR_GPIO_WAKE_LSB      0
// Reset values
`define DAR_HS_INTERVAL_RST    8'h04
`define DAR_FS_INTERVAL_RST    8'h01
`define DAR_LEN_RST            8'h00
`define DAR_PTR_RST            11'h000
// AXI responses
`define DAR_RESP_OKAY          2'h0
`define DAR_RESP_SLVERR        2'h2
`endif

// ---- rtl/dar_descriptor_attribute_regs.v ----
// Descriptor attribute and transmit FIFO pointer debug registers on AXI4-Lite
//
// Design decision made here: the AXI4-Lite slave port.
`include "dar_regs.vh"

// Overview of the block
// One AXI4-Lite slave with six word registers.
// Write address and write data are caught in any order.
// A write commits one edge after both halves are held.
// The write answer rises on that commit edge.
// A read is taken whenever no read answer is pending.
// The read answer rises on the same edge that takes the read.
// Answers stand until the master takes them.
// Unmapped places answer with a slave error.
// Writes to the pointer view are answered and dropped.
// Writes under reset protection are answered and dropped.
// Legal size values are left to software to keep.

module dar_descriptor_attribute_regs #(
  parameter PTR_W = 11
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite write address
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  // Transmit FIFO pointers from the FIFO
  input  wire [PTR_W-1:0]  tx_fifo_read_position,
  input  wire [PTR_W-1:0]  tx_fifo_write_position,
  // Straps, presence and protection
  input  wire              host_wakeup_strap,
  input  wire              supply_select_strap,
  input  wire              eeprom_present,
  input  wire              rom_emulation_enable,
  input  wire              reset_protect,
  // Attribute values to descriptor processing
  output wire              attributes_active,
  output wire [7:0]        high_speed_interval,
  output wire [7:0]        high_speed_device_len,
  output wire [7:0]        high_speed_config_len,
  output wire [7:0]        full_speed_interval,
  output wire [7:0]        full_speed_device_len,
  output wire [7:0]        full_speed_config_len,
  output wire [7:0]        config_string_len,
  output wire [7:0]        serial_string_len,
  output wire [7:0]        product_string_len,
  output wire [7:0]        maker_string_len,
  output wire [7:0]        interface_string_len,
  output wire              host_wakeup_support,
  output wire              supply_source_select,
  output wire [7:0]        gpio_wake_event_flags
);

  // Attribute storage
  reg  [7:0]        hs_int_ff;           // High-speed interval
  reg  [7:0]        hs_dev_ff;           // High-speed device size
  reg  [7:0]        hs_cfg_ff;           // High-speed config size
  reg  [7:0]        fs_int_ff;           // Full-speed interval
  reg  [7:0]        fs_dev_ff;           // Full-speed device size
  reg  [7:0]        fs_cfg_ff;           // Full-speed config size
  reg  [31:0]       str_a_ff;            // Four string lengths
  reg  [7:0]        str_b_ff;            // Interface string length
  reg               wake_ff;             // Host wakeup support
  reg               supply_ff;           // Supply source select
  reg  [7:0]        gpio_ff;             // GPIO wake flags
  reg               strap_pend_ff;       // Straps still to be caught
  // Pointer capture
  reg  [PTR_W-1:0]  rd_pos_ff;           // Registered read pointer
  reg  [PTR_W-1:0]  wr_pos_ff;           // Registered write pointer
  // Write channel state
  reg  [7:0]        aw_addr_ff;          // Held write address
  reg               aw_full_ff;          // Write address taken
  reg  [31:0]       w_data_ff;           // Held write data
  reg  [3:0]        w_strb_ff;           // Held byte strobes
  reg               w_full_ff;           // Write data taken
  reg               bvalid_ff;           // Write response pending
  reg  [1:0]        bresp_ff;            // Write response code
  // Read channel state
  reg               rvalid_ff;           // Read data pending
  reg  [31:0]       rdata_ff;            // Read data
  reg  [1:0]        rresp_ff;            // Read response code
  // Decode helpers
  reg  [31:0]       nxt_rdata;           // Read mux result
  reg               nxt_rd_hit;          // Read address mapped
  reg               wr_hit;              // Write address mapped
  reg  [31:0]       wmask;               // Byte mask from strobes
  wire              do_write;            // Write commits this edge
  wire              wr_allow;            // Protection lets the write in
  wire              do_read;             // Read taken this edge

  // Handshakes: one write and one read at a time
  // Each half of a write is refused once held.
  // Both halves are refused while an answer waits.
  // The read address is refused while read data waits.
  // A commit needs both halves and a free answer slot.
  // Protection only blocks the storage update.
  assign s_axi_awready = ~aw_full_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_full_ff & ~bvalid_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign do_write      = aw_full_ff & w_full_ff & ~bvalid_ff;
  assign do_read       = s_axi_arvalid & ~rvalid_ff;
  assign wr_allow      = ~reset_protect;

  // Outputs
  // Bus answers come straight from flip-flops.
  // Attribute fields feed descriptor handling directly.
  // The gate says whether those fields are in use.
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;
  assign attributes_active     = ~eeprom_present & rom_emulation_enable;
  assign high_speed_interval   = hs_int_ff;
  assign high_speed_device_len = hs_dev_ff;
  assign high_speed_config_len = hs_cfg_ff;
  assign full_speed_interval   = fs_int_ff;
  assign full_speed_device_len = fs_dev_ff;
  assign full_speed_config_len = fs_cfg_ff;
  assign config_string_len     = str_a_ff[31:24];
  assign serial_string_len     = str_a_ff[23:16];
  assign product_string_len    = str_a_ff[15:8];
  assign maker_string_len      = str_a_ff[7:0];
  assign interface_string_len  = str_b_ff;
  assign host_wakeup_support   = wake_ff;
  assign supply_source_select  = supply_ff;
  assign gpio_wake_event_flags = gpio_ff;

  // Byte mask and write address decode
  // Works on the held address, not the live one.
  // The mask turns each strobe into eight bit enables.
  // A hit decides between OKAY and slave error.
  // The pointer view counts as a hit, writes ignored.
  always @* begin
    wmask  = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
    wr_hit = 1'b0;
    if (aw_addr_ff == `DAR_TX_PTR_DEBUG_OFF) begin
      wr_hit = 1'b1;                     // Read-only, write dropped
    end else if (aw_addr_ff == `DAR_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES_OFF) begin
      wr_hit = 1'b1;
    end else if (aw_addr_ff == `DAR_FULL_SPEED_DESCRIPTOR_ATTRIBUTES_OFF) begin
      wr_hit = 1'b1;
    end else if (aw_addr_ff == `DAR_STR_LEN_A_OFF) begin
      wr_hit = 1'b1;
    end else if (aw_addr_ff == `DAR_STR_LEN_B_OFF) begin
      wr_hit = 1'b1;
    end else if (aw_addr_ff == `DAR_EMULATED_FLAG_ATTRIBUTES_OFF) begin
      wr_hit = 1'b1;
    end
  end

  // Read mux; reserved bits are zero
  // Works on the live read address.
  // Its result is caught only on a taken read.
  // Pointer fields come from the captured copies.
  // Unmapped places read as zero with an error.
  always @* begin
    nxt_rdata  = 32'h00000000;
    nxt_rd_hit = 1'b1;
    if (s_axi_araddr == `DAR_TX_PTR_DEBUG_OFF) begin
      nxt_rdata[`DAR_RD_POS_LSB +: PTR_W] = rd_pos_ff;
      nxt_rdata[`DAR_WR_POS_LSB +: PTR_W] = wr_pos_ff;
    end else if (s_axi_araddr == `DAR_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES_OFF) begin
      nxt_rdata = {8'h00, hs_int_ff, hs_dev_ff, hs_cfg_ff};
    end else if (s_axi_araddr == `DAR_FULL_SPEED_DESCRIPTOR_ATTRIBUTES_OFF) begin
      nxt_rdata = {8'h00, fs_int_ff, fs_dev_ff, fs_cfg_ff};
    end else if (s_axi_araddr == `DAR_STR_LEN_A_OFF) begin
      nxt_rdata = str_a_ff;
    end else if (s_axi_araddr == `DAR_STR_LEN_B_OFF) begin
      nxt_rdata = {24'h000000, str_b_ff};
    end else if (s_axi_araddr == `DAR_EMULATED_FLAG_ATTRIBUTES_OFF) begin
      nxt_rdata = {14'h0000, wake_ff, supply_ff, 8'h00, gpio_ff};
    end else begin
      nxt_rd_hit = 1'b0;                 // Unmapped address
    end
  end

  // Pointer capture from the FIFO
  // One register stage between FIFO and bus.
  // Read data thus shows pointers one edge old.
  // Both copies clear to zero in reset.
  // Nothing here can be written by software.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_pos_ff <= `DAR_PTR_RST;
      wr_pos_ff <= `DAR_PTR_RST;
    end else begin
      rd_pos_ff <= tx_fifo_read_position;
      wr_pos_ff <= tx_fifo_write_position;
    end
  end

  // Write channel
  // Address and data halves are held separately.
  // Each holder empties on the commit edge.
  // The answer code is fixed at commit time.
  // The answer drops on the edge bready is seen.
  // A new write cannot commit while an answer waits.
  // Low address bits are dropped: word access only.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_full_ff  <= 1'b0;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `DAR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_ff <= 1'b0;
        w_full_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_hit ? `DAR_RESP_OKAY : `DAR_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Attribute registers; straps caught one edge after release
  // Straps are sampled once, on the first free edge.
  // Until then the two flag bits read zero.
  // A write cannot commit on that edge anyway.
  // Each byte lane updates only with its strobe.
  // Flag bits 17 and 16 need strobe lane two.
  // Reserved bits have no storage at all.
  // Protection freezes every field held here against bus writes.
  always @(posedge aclk) begin
    if (!aresetn) begin
      hs_int_ff     <= `DAR_HS_INTERVAL_RST;
      hs_dev_ff     <= `DAR_LEN_RST;
      hs_cfg_ff     <= `DAR_LEN_RST;
      fs_int_ff     <= `DAR_FS_INTERVAL_RST;
      fs_dev_ff     <= `DAR_LEN_RST;
      fs_cfg_ff     <= `DAR_LEN_RST;
      str_a_ff      <= 32'h00000000;
      str_b_ff      <= `DAR_LEN_RST;
      wake_ff       <= 1'b0;
      supply_ff     <= 1'b0;
      gpio_ff       <= `DAR_LEN_RST;
      strap_pend_ff <= 1'b1;
    end else begin
      if (strap_pend_ff) begin
        strap_pend_ff <= 1'b0;
        wake_ff       <= host_wakeup_strap;
        supply_ff     <= supply_select_strap;
      end
      if (do_write && wr_allow) begin
        if (aw_addr_ff == `DAR_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES_OFF) begin
          hs_int_ff <= (hs_int_ff & ~wmask[23:16]) | (w_data_ff[23:16] & wmask[23:16]);
          hs_dev_ff <= (hs_dev_ff & ~wmask[15:8]) | (w_data_ff[15:8] & wmask[15:8]);
          hs_cfg_ff <= (hs_cfg_ff & ~wmask[7:0]) | (w_data_ff[7:0] & wmask[7:0]);
        end else if (aw_addr_ff == `DAR_FULL_SPEED_DESCRIPTOR_ATTRIBUTES_OFF) begin
          fs_int_ff <= (fs_int_ff & ~wmask[23:16]) | (w_data_ff[23:16] & wmask[23:16]);
          fs_dev_ff <= (fs_dev_ff & ~wmask[15:8]) | (w_data_ff[15:8] & wmask[15:8]);
          fs_cfg_ff <= (fs_cfg_ff & ~wmask[7:0]) | (w_data_ff[7:0] & wmask[7:0]);
        end else if (aw_addr_ff == `DAR_STR_LEN_A_OFF) begin
          str_a_ff <= (str_a_ff & ~wmask) | (w_data_ff & wmask);
        end else if (aw_addr_ff == `DAR_STR_LEN_B_OFF) begin
          str_b_ff <= (str_b_ff & ~wmask[7:0]) | (w_data_ff[7:0] & wmask[7:0]);
        end else if (aw_addr_ff == `DAR_EMULATED_FLAG_ATTRIBUTES_OFF) begin
          if (w_strb_ff[2]) begin
            wake_ff   <= w_data_ff[`DAR_HOST_WAKEUP_BIT];
            supply_ff <= w_data_ff[`DAR_SUPPLY_SEL_BIT];
          end
          gpio_ff <= (gpio_ff & ~wmask[7:0]) | (w_data_ff[7:0] & wmask[7:0]);
        end
      end
    end
  end

  // Read channel
  // Data and code are caught with the read.
  // They stand until rready is seen high.
  // A new read waits for the slot to clear.
  // Read data hold their value after the answer.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `DAR_RESP_OKAY;
    end else if (do_read) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rd_hit ? `DAR_RESP_OKAY : `DAR_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule // dar_descriptor_attribute_regs

// ---- testbench/dar_regs_chk.sv ----
// Bus and register checker for the descriptor attribute registers
module dar_regs_chk #(parameter int PTR_W = 11) (
  // Clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // Register bus
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [7:0]       s_axi_araddr,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [31:0]      s_axi_rdata,
  // Pointers, straps and controls
  input wire logic [PTR_W-1:0] tx_fifo_read_position,
  input wire logic [PTR_W-1:0] tx_fifo_write_position,
  input wire logic             host_wakeup_strap,
  input wire logic             eeprom_present,
  input wire logic             rom_emulation_enable,
  input wire logic             reset_protect,
  // Register outputs
  input wire logic             attributes_active,
  input wire logic             host_wakeup_support,
  input wire logic [7:0]       high_speed_interval,
  input wire logic [7:0]       full_speed_interval
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, reset disables all
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers stand until taken
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  property p_ar_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_ar_ans: assert property (p_ar_ans) else $error("read not answered next cycle");
  // Pointer debug word, reserved bits zero
  property p_ptr; s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h1F |=> s_axi_rdata ==
    {5'h00, $past(tx_fifo_read_position, 2), 5'h00, $past(tx_fifo_write_position, 2)}; endproperty
  a_ptr: assert property (p_ptr) else $error("pointer debug word wrong");
  property p_active; attributes_active == (!eeprom_present && rom_emulation_enable); endproperty
  a_active: assert property (p_active) else $error("attribute gate wrong");
  property p_protect; reset_protect |=> $stable(high_speed_interval) && $stable(full_speed_interval); endproperty
  a_protect: assert property (p_protect) else $error("protected register changed");
  property p_strap; $rose(aresetn) |=> host_wakeup_support == $past(host_wakeup_strap); endproperty
  a_strap: assert property (p_strap) else $error("wakeup strap not loaded");
  property p_rst_val; $rose(aresetn) |-> high_speed_interval == 8'h04 && full_speed_interval == 8'h01; endproperty
  a_rst_val: assert property (p_rst_val) else $error("interval reset value wrong");
  // Main scenarios seen
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_protect: cover property (reset_protect && s_axi_bvalid);
endmodule // dar_regs_chk
bind dar_descriptor_attribute_regs dar_regs_chk #(.PTR_W(PTR_W)) u_chk (.*);

// ---- testbench/dar_descriptor_attribute_regs_test.sv ----
// Self-checking bench for the descriptor attribute registers
`include "dar_regs.vh"
module dar_descriptor_attribute_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Driven inputs
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, host_wakeup_strap, supply_select_strap;
  logic        eeprom_present, rom_emulation_enable, reset_protect;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic [10:0] tx_fifo_read_position, tx_fifo_write_position;
  // Observed outputs
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         attributes_active, host_wakeup_support, supply_source_select;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [7:0]  high_speed_interval, high_speed_device_len, high_speed_config_len;
  wire  [7:0]  full_speed_interval, full_speed_device_len, full_speed_config_len;
  wire  [7:0]  config_string_len, serial_string_len, product_string_len, maker_string_len;
  wire  [7:0]  interface_string_len, gpio_wake_event_flags;
  int          error_cnt, n_checks;
  // Device under test
  dar_descriptor_attribute_regs #(.PTR_W(11)) uut (.*);
  // 100 MHz clock
  always #5 aclk = ~aclk;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus write, address and data offered together, answer must be OKAY
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ah;
    logic wh;
    @(posedge aclk);
    ah = 0;
    wh = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ah && wh)) begin
      @(negedge aclk);
      ah = ah | s_axi_awready;
      wh = wh | s_axi_wready;
      @(posedge aclk);
      s_axi_awvalid <= !ah;
      s_axi_wvalid <= !wh;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, 32'h0);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  // Bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  // Reset values of every register
  task automatic t_reset;
    rd(`DAR_TX_PTR_DEBUG_OFF, 32'h0, 2'h0);
    rd(`DAR_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES_OFF, 32'h00040000, 2'h0);
    rd(`DAR_FULL_SPEED_DESCRIPTOR_ATTRIBUTES_OFF, 32'h00010000, 2'h0);
    rd(`DAR_STR_LEN_A_OFF, 32'h0, 2'h0);
    rd(`DAR_STR_LEN_B_OFF, 32'h0, 2'h0);
    rd(`DAR_EMULATED_FLAG_ATTRIBUTES_OFF, 32'h00020000, 2'h0);
    $display("reset value test done");
  endtask
  // Writable fields, reserved bits, byte lanes
  task automatic t_rw;
    wr(`DAR_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES_OFF, 32'hFF2A1212, 4'hF);
    rd(`DAR_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES_OFF, 32'h002A1212, 2'h0);
    @(negedge aclk);
    chk({8'h0, high_speed_interval, high_speed_device_len, high_speed_config_len}, 32'h2A1212);
    wr(`DAR_FULL_SPEED_DESCRIPTOR_ATTRIBUTES_OFF, 32'hFF051200, 4'hF);
    rd(`DAR_FULL_SPEED_DESCRIPTOR_ATTRIBUTES_OFF, 32'h00051200, 2'h0);
    wr(`DAR_STR_LEN_A_OFF, 32'h11223344, 4'hF);
    @(negedge aclk);
    chk({config_string_len, serial_string_len, product_string_len, maker_string_len}, 32'h11223344);
    wr(`DAR_STR_LEN_B_OFF, 32'hFFFFFF09, 4'hF);
    rd(`DAR_STR_LEN_B_OFF, 32'h00000009, 2'h0);
    wr(`DAR_EMULATED_FLAG_ATTRIBUTES_OFF, 32'hFFFFFFFF, 4'hF);
    rd(`DAR_EMULATED_FLAG_ATTRIBUTES_OFF, 32'h000300FF, 2'h0);
    wr(`DAR_EMULATED_FLAG_ATTRIBUTES_OFF, 32'h0, 4'h1);
    rd(`DAR_EMULATED_FLAG_ATTRIBUTES_OFF, 32'h00030000, 2'h0);
    wr(`DAR_EMULATED_FLAG_ATTRIBUTES_OFF, 32'h0, 4'h4);
    @(negedge aclk);
    chk({30'h0, host_wakeup_support, supply_source_select}, 32'h0);
    $display("read write test done");
  endtask
  // Pointer view, read-only write, unmapped place
  task automatic t_ptr;
    @(posedge aclk);
    tx_fifo_read_position <= 11'h5A5;
    tx_fifo_write_position <= 11'h2AB;
    wr(`DAR_TX_PTR_DEBUG_OFF, 32'hFFFFFFFF, 4'hF);
    rd(`DAR_TX_PTR_DEBUG_OFF, 32'h05A502AB, 2'h0);
    rd(8'hB4, 32'h0, 2'h2);
    $display("pointer test done");
  endtask
  // Protection and descriptor gate
  task automatic t_prot;
    @(posedge aclk);
    reset_protect <= 1'b1;
    wr(`DAR_STR_LEN_A_OFF, 32'h0, 4'hF);
    rd(`DAR_STR_LEN_A_OFF, 32'h11223344, 2'h0);
    @(posedge aclk);
    reset_protect <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      eeprom_present <= i[1];
      rom_emulation_enable <= i[0];
      @(negedge aclk);
      chk({31'h0, attributes_active}, {31'h0, !i[1] && i[0]});
    end
    $display("protection test done");
  endtask
  // Second reset with other strap levels
  task automatic t_strap;
    @(posedge aclk);
    host_wakeup_strap <= 1'b0;
    supply_select_strap <= 1'b1;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`DAR_EMULATED_FLAG_ATTRIBUTES_OFF, 32'h00010000, 2'h0);
    rd(`DAR_HIGH_SPEED_DESCRIPTOR_ATTRIBUTES_OFF, 32'h00040000, 2'h0);
    $display("strap test done");
  endtask
  // Counts, verdict, end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #100us;
    error_cnt++;
    stop_test();
  end
  // Main sequence
  initial begin
    aclk = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
     s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, tx_fifo_read_position,
     tx_fifo_write_position, eeprom_present, supply_select_strap, reset_protect} = '0;
    host_wakeup_strap = 1'b1;
    rom_emulation_enable = 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_rw();
    t_ptr();
    t_prot();
    t_strap();
    stop_test();
  end
endmodule // dar_descriptor_attribute_regs_test
